// [shared/isel_pkg.sv]
// constants and types for the interface select and power control block
package isel_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] STAT_IDX = 8'h11;
   localparam logic [7:0] CTRL_IDX = 8'h12;
   localparam int ADDR_LSB = 2;
   localparam int IDX_W = 8;
   // status fields
   localparam int STAT_ACT0_BIT = 5;
   localparam int STAT_DCLK_BIT = 4;
   // control fields
   localparam int CTRL_OVR_BIT = 7;
   localparam int CTRL_PICK_BIT = 6;
   localparam int CTRL_PWR_BIT = 0;
   localparam logic [7:0] CTRL_WMASK = 8'hC1;
   localparam logic [7:0] CTRL_RST = 8'h01;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   typedef enum logic [2:0] {
      MODE_NONE = 3'b001,
      MODE_ANALOG = 3'b010,
      MODE_DIGITAL = 3'b100
   } mode_t;
endpackage : isel_pkg

// [rtl/source_decide.sv]
// decides which interface is active from control bits and detect levels
`timescale 1ns/1ps
`default_nettype none
module source_decide (
   input wire logic override_bit,
   input wire logic pick_bit,
   input wire logic power_bit,
   input wire logic analog_act,
   input wire logic digital_act,
   output isel_pkg::mode_t mode
);
   always_comb begin
      if (!power_bit) begin
         mode = isel_pkg::MODE_NONE;
      end else if (override_bit) begin
         mode = pick_bit ? isel_pkg::MODE_DIGITAL : isel_pkg::MODE_ANALOG;
      end else if (analog_act) begin
         // without override analog wins; the internal clock detect is weak
         mode = isel_pkg::MODE_ANALOG;
      end else if (digital_act) begin
         mode = isel_pkg::MODE_DIGITAL;
      end else begin
         mode = isel_pkg::MODE_NONE;
      end
   end
endmodule : source_decide
`default_nettype wire

// [rtl/interface_select_power_control.sv]
// top: ahb-lite register slave, interface selection and power enables
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module interface_select_power_control (
   input wire logic clock,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [2:0] analog_detect,
   input wire logic digital_clock_detect,
   output logic analog_power,
   output logic digital_power,
   output logic line_sync_detect_power,
   output logic shared_power,
   output logic route_digital,
   output logic route_enable,
   output logic sync_activity_out
);
   function automatic logic [isel_pkg::IDX_W-1:0] idx_of(input logic [31:0] a);
      idx_of = a[isel_pkg::ADDR_LSB +: isel_pkg::IDX_W];
   endfunction : idx_of

   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic wr_pend_r;
   logic wr_pend_nxt;
   logic [isel_pkg::IDX_W-1:0] wr_idx_r;
   logic [isel_pkg::IDX_W-1:0] wr_idx_nxt;
   logic [31:0] hrdata_r;
   logic [31:0] hrdata_nxt;
   logic [7:0] status;
   logic addr_ok;
   logic [7:0] ctrl_view;
   isel_pkg::mode_t mode_d;
   isel_pkg::mode_t mode_r;
   logic a_pwr_nxt;
   logic d_pwr_nxt;
   logic ls_pwr_nxt;
   logic sh_pwr_nxt;
   logic rt_dig_nxt;
   logic rt_en_nxt;
   logic act_nxt;
   logic a_pwr_r;
   logic d_pwr_r;
   logic ls_pwr_r;
   logic sh_pwr_r;
   logic rt_dig_r;
   logic rt_en_r;
   logic act_r;
   logic analog_any;

   assign analog_any = |analog_detect;
   assign status = {analog_detect, digital_clock_detect, 4'h0};
   assign addr_ok = hsel && hready && (htrans == isel_pkg::HTRANS_NONSEQ ||
                    htrans == isel_pkg::HTRANS_SEQ);

   // bus logic has no power gating
   always_comb begin
      ctrl_nxt = ctrl_r;
      wr_pend_nxt = 1'b0;
      wr_idx_nxt = wr_idx_r;
      hrdata_nxt = hrdata_r;
      if (wr_pend_r && wr_idx_r == isel_pkg::CTRL_IDX) begin
         ctrl_nxt = hwdata[7:0] & isel_pkg::CTRL_WMASK;
      end
      ctrl_view = ctrl_nxt;
      if (addr_ok) begin
         wr_pend_nxt = hwrite;
         wr_idx_nxt = idx_of(haddr);
         // read mux, forwarding a write still in flight
         if (!hwrite) begin
            case (idx_of(haddr))
               isel_pkg::STAT_IDX: hrdata_nxt = {24'h000000, status};
               isel_pkg::CTRL_IDX: hrdata_nxt = {24'h000000, ctrl_view};
               default: hrdata_nxt = 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_r <= isel_pkg::CTRL_RST;
         wr_pend_r <= 1'b0;
         wr_idx_r <= 8'h00;
         hrdata_r <= 32'h00000000;
      end else begin
         ctrl_r <= ctrl_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_idx_r <= wr_idx_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   source_decide u_decide (
      .override_bit(ctrl_r[isel_pkg::CTRL_OVR_BIT]),
      .pick_bit(ctrl_r[isel_pkg::CTRL_PICK_BIT]),
      .power_bit(ctrl_r[isel_pkg::CTRL_PWR_BIT]),
      .analog_act(analog_any),
      .digital_act(digital_clock_detect),
      .mode(mode_d)
   );

   always_comb begin
      a_pwr_nxt = 1'b0;
      d_pwr_nxt = 1'b0;
      ls_pwr_nxt = 1'b0;
      sh_pwr_nxt = 1'b0;
      rt_dig_nxt = 1'b0;
      rt_en_nxt = 1'b0;
      act_nxt = 1'b0;
      case (mode_d)
         isel_pkg::MODE_NONE: begin
            act_nxt = 1'b0;
         end
         isel_pkg::MODE_ANALOG: begin
            a_pwr_nxt = 1'b1;
            ls_pwr_nxt = 1'b1;
            sh_pwr_nxt = 1'b1;
            rt_en_nxt = 1'b1;
            act_nxt = analog_any;
         end
         isel_pkg::MODE_DIGITAL: begin
            d_pwr_nxt = 1'b1;
            ls_pwr_nxt = 1'b1;
            sh_pwr_nxt = 1'b1;
            rt_dig_nxt = 1'b1;
            rt_en_nxt = 1'b1;
            act_nxt = digital_clock_detect;
         end
         default: begin
            act_nxt = 1'b0;
         end
      endcase
   end

   // no reset on mode change, one cycle after the write
   always_ff @(posedge clock) begin
      if (reset) begin
         mode_r <= isel_pkg::MODE_NONE;
         a_pwr_r <= 1'b0;
         d_pwr_r <= 1'b0;
         ls_pwr_r <= 1'b0;
         sh_pwr_r <= 1'b0;
         rt_dig_r <= 1'b0;
         rt_en_r <= 1'b0;
         act_r <= 1'b0;
      end else begin
         mode_r <= mode_d;
         a_pwr_r <= a_pwr_nxt;
         d_pwr_r <= d_pwr_nxt;
         ls_pwr_r <= ls_pwr_nxt;
         // shared circuits up if either active
         sh_pwr_r <= sh_pwr_nxt;
         rt_dig_r <= rt_dig_nxt;
         rt_en_r <= rt_en_nxt;
         act_r <= act_nxt;
      end
   end

   assign analog_power = a_pwr_r;
   assign digital_power = d_pwr_r;
   assign line_sync_detect_power = ls_pwr_r;
   assign shared_power = sh_pwr_r;
   assign route_digital = rt_dig_r;
   assign route_enable = rt_en_r;
   assign sync_activity_out = act_r;

   // checks
   sequence s_ctrl_write;
      addr_ok && hwrite && idx_of(haddr) == isel_pkg::CTRL_IDX;
   endsequence

   property p_force_pick;
      @(posedge clock) disable iff (reset)
      s_ctrl_write ##1 (hwdata[isel_pkg::CTRL_PWR_BIT] && hwdata[isel_pkg::CTRL_OVR_BIT])
      |=> ##1 (analog_power == !$past(hwdata[isel_pkg::CTRL_PICK_BIT], 2)) &&
          (digital_power == $past(hwdata[isel_pkg::CTRL_PICK_BIT], 2));
   endproperty
   a_force_pick: assert property (p_force_pick) else $error("override pick not applied");

   property p_power_off;
      @(posedge clock) disable iff (reset)
      !ctrl_r[isel_pkg::CTRL_PWR_BIT] |=> !analog_power && !digital_power &&
         !sync_activity_out && !shared_power && !route_enable;
   endproperty
   a_power_off: assert property (p_power_off) else $error("power-down not honoured");

   property p_exclusive;
      @(posedge clock) disable iff (reset)
      !(analog_power && digital_power);
   endproperty
   a_exclusive: assert property (p_exclusive) else $error("both interfaces powered");

   property p_line_sync;
      @(posedge clock) disable iff (reset)
      digital_power |-> line_sync_detect_power;
   endproperty
   a_line_sync: assert property (p_line_sync) else $error("line sync detect dropped");

   property p_shared;
      @(posedge clock) disable iff (reset)
      shared_power == (analog_power || digital_power);
   endproperty
   a_shared: assert property (p_shared) else $error("shared circuits power wrong");

   property p_bus_alive;
      @(posedge clock) disable iff (reset)
      (addr_ok && !hwrite && idx_of(haddr) == isel_pkg::STAT_IDX && !analog_power &&
       !digital_power) |=> hrdata[7:0] == $past(status) && hreadyout;
   endproperty
   a_bus_alive: assert property (p_bus_alive) else $error("bus dead in power-down");

   property p_route;
      @(posedge clock) disable iff (reset)
      route_enable |-> route_digital == digital_power && (analog_power != digital_power);
   endproperty
   a_route: assert property (p_route) else $error("route does not match source");

   property p_ctrl_store;
      @(posedge clock) disable iff (reset)
      s_ctrl_write |=> ##1 ctrl_r == ($past(hwdata[7:0]) & isel_pkg::CTRL_WMASK);
   endproperty
   a_ctrl_store: assert property (p_ctrl_store) else $error("control write lost");

   property p_apply;
      @(posedge clock) disable iff (reset)
      $changed(ctrl_r) && ctrl_r[isel_pkg::CTRL_PWR_BIT] && ctrl_r[isel_pkg::CTRL_OVR_BIT] |=>
         route_enable && (route_digital == $past(ctrl_r[isel_pkg::CTRL_PICK_BIT])) &&
         (mode_r == ($past(ctrl_r[isel_pkg::CTRL_PICK_BIT]) ? isel_pkg::MODE_DIGITAL :
         isel_pkg::MODE_ANALOG));
   endproperty
   a_apply: assert property (p_apply) else $error("mode not applied next cycle");
endmodule : interface_select_power_control
`default_nettype wire

// [tb/sys_ctrl_model.sv]
// system controller model: ahb-lite master and interface selection policy
`timescale 1ns/1ps
`default_nettype none
module sys_ctrl_model (
   input wire logic clock,
   input wire logic hready,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   logic hot_plug = 1'b0;
   logic on_digital = 1'b0;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // bounded wait: a stuck bus ends the run as a failure
   task wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) begin
         tb_top.fail_count++;
         tb_top.report_and_stop();
      end
   endtask : wait_ready
   task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= isel_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= 3'h2;
      // flag a hot-plug event when a control write first forces the digital side (bits 7, 6 and 0 set)
      if (w && idx == isel_pkg::CTRL_IDX) begin
         hot_plug <= d[7] && d[6] && d[0] && !on_digital;
         on_digital <= d[7] && d[6] && d[0];
      end
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      hsel <= 1'b0;
      // released data bus shows a changed value, not a stale one
      hwdata <= ~d;
      // one idle edge so the next call never rewrites hsel in this step
      @(posedge clock);
   endtask : xfer
   function automatic logic [7:0] policy(input logic [2:0] adet, input logic dclk, input logic pri);
      logic act;
      act = |adet;
      if (!act && !dclk) return 8'h80;
      return {1'b1, act ? (dclk & pri) : 1'b1, 5'h0, 1'b1};
   endfunction : policy
endmodule : sys_ctrl_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for interface select and power control
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module tb_top;
   logic clock, reset, hsel, hwrite, hreadyout, hresp, dclk;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, adet;
   logic [6:0] pins;
   int fail_count = 0;
   int total_checks = 0;
   typedef struct packed {logic rd; logic [31:0] v;} note_t;
   note_t q[$];
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   sys_ctrl_model ctrl (.clock(clock), .hready(hreadyout), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   interface_select_power_control uut (.clock(clock), .reset(reset), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .analog_detect(adet), .digital_clock_detect(dclk), .analog_power(pins[6]),
      .digital_power(pins[5]), .line_sync_detect_power(pins[4]), .shared_power(pins[3]),
      .route_digital(pins[2]), .route_enable(pins[1]), .sync_activity_out(pins[0]));
   function automatic logic [31:0] exp_pins(input logic [7:0] c, input logic [2:0] a,
      input logic d);
      logic dig;
      if (!c[0] || (!c[7] && a == 3'h0 && !d)) return 32'h0;
      dig = c[7] ? c[6] : (a == 3'h0);
      return dig ? {25'h0, 6'h1F, d} : {25'h0, 6'h2D, |a};
   endfunction : exp_pins
   task note(input logic rd, input logic [31:0] v);
      q.push_back({rd, v});
   endtask : note
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   initial begin
      note_t n;
      forever begin
         wait (q.size() != 0);
         // look off the edge, while the noted result stands
         #1;
         while (q.size() != 0) begin
            n = q.pop_front();
            if (n.rd)
               `CHECK({hresp, hrdata}, {1'b0, n.v})
            else
               `CHECK({25'h0, pins}, n.v)
         end
      end
   end
   initial begin
      logic [7:0] c, junk;
      logic [2:0] a;
      logic d, pri;
      int m;
      reset = 1'b1;
      adet = 3'h0;
      dclk = 1'b1;
      m = $urandom(32'h6058);
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      ctrl.xfer(1'b0, isel_pkg::CTRL_IDX, 32'h0);
      note(1'b1, 32'h1);
      note(1'b0, exp_pins(8'h01, 3'h0, 1'b1));
      $display("test reset values done");
      repeat (40) begin
         m = $urandom % 4;
         a = 3'($urandom);
         d = 1'($urandom);
         pri = 1'($urandom);
         junk = 8'($urandom);
         adet <= a;
         dclk <= d;
         case (m)
            0: c = ctrl.policy(a, d, pri);
            1: c = {1'b1, pri, 6'h1};
            2: c = {1'b0, pri, 6'h1};
            default: c = {junk[7:6], 6'h0};
         endcase
         // reserved bits written with noise must read back as zero
         c = c | (junk & 8'h3E);
         ctrl.xfer(1'b1, isel_pkg::CTRL_IDX, {24'h0, c});
         @(posedge clock);
         note(1'b0, exp_pins(c, a, d));
         ctrl.xfer(1'b0, isel_pkg::CTRL_IDX, 32'h0);
         note(1'b1, {24'h0, c & isel_pkg::CTRL_WMASK});
         ctrl.xfer(1'b0, isel_pkg::STAT_IDX, 32'h0);
         note(1'b1, {24'h0, a, d, 4'h0});
      end
      $display("test random selection done");
      ctrl.xfer(1'b1, 8'h13, 32'hFF);
      ctrl.xfer(1'b0, 8'h13, 32'h0);
      note(1'b1, 32'h0);
      $display("test unmapped done");
      // let the checker drain the last notes before the verdict
      repeat (2) @(posedge clock);
      if (q.size() != 0)
         fail_count++;
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
